/* File: src/iotr_pkg.sv */
// Shared constants for the I/O test and output override register group
package iotr_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [5:0] IDX_TEST3 = 6'h28;
  localparam logic [5:0] IDX_TEST4 = 6'h29;
  localparam logic [5:0] IDX_TEST5 = 6'h2a;
  localparam logic [5:0] IDX_TEST6 = 6'h2b;
  localparam logic [5:0] IDX_TEST7 = 6'h2c;
  localparam logic [5:0] IDX_CTRL = 6'h2d;
  localparam logic [5:0] IDX_TRIM_AB = 6'h2e;
  localparam logic [5:0] IDX_TRIM_CD = 6'h2f;
  localparam logic [5:0] IDX_OVR = 6'h30;
  localparam logic [5:0] IDX_FIRST = IDX_TEST3;
  localparam logic [5:0] IDX_LAST = IDX_OVR;

  // Storage slots, counted from the first index
  localparam int REG_COUNT = 9;
  localparam logic [3:0] SLOT_TEST3 = 4'h0;
  localparam logic [3:0] SLOT_TEST4 = 4'h1;
  localparam logic [3:0] SLOT_TEST5 = 4'h2;
  localparam logic [3:0] SLOT_TEST6 = 4'h3;
  localparam logic [3:0] SLOT_TEST7 = 4'h4;
  localparam logic [3:0] SLOT_CTRL = 4'h5;
  localparam logic [3:0] SLOT_TRIM_AB = 4'h6;
  localparam logic [3:0] SLOT_TRIM_CD = 4'h7;
  localparam logic [3:0] SLOT_OVR = 4'h8;

  // Reset values
  localparam logic [15:0] RST_TEST3 = 16'h4545;
  localparam logic [15:0] RST_TEST4 = 16'h1a1a;
  localparam logic [15:0] RST_TEST5 = 16'h1616;
  localparam logic [15:0] RST_TEST6 = 16'haaaa;
  localparam logic [15:0] RST_TEST7 = 16'hc6c6;
  localparam logic [15:0] RST_CTRL = 16'h0004;
  localparam logic [15:0] RST_TRIM = 16'h0000;
  localparam logic [15:0] RST_OVR = 16'h0000;
  localparam logic [15:0] RST_TABLE [0:8] = '{RST_TEST3, RST_TEST4,
    RST_TEST5, RST_TEST6, RST_TEST7, RST_CTRL, RST_TRIM, RST_TRIM,
    RST_OVR};

  // Control word fields
  localparam int CTRL_STROBE_BIT = 14;
  localparam int CTRL_RAMP_BIT = 13;
  localparam int CTRL_OVR_BIT = 0;

  // Trim byte fields and sample layout
  localparam int TRIM_HI_LSB = 8;
  localparam int SAMPLE_MSB = 15;
  localparam logic [15:0] RAMP_STEP = 16'h0001;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [31:0] ZERO_BUS = 32'h0000_0000;

endpackage : iotr_pkg

/* File: src/iotr_ovr_latch.sv */
// Override value capture on rising edges of the input data clock
`timescale 1ns/10ps
module iotr_ovr_latch
(
  input wire logic clk,
  input wire logic reset,
  input wire logic input_ddr_clock,
  input wire logic [15:0] value_in,
  output logic [15:0] value_out
);

  logic ddr_prev;
  wire ddr_rise;

  // Data clock is sampled as a plain synchronous input
  assign ddr_rise = input_ddr_clock & ~ddr_prev;

  // Capture only on a data clock rising edge; a stopped clock holds
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ddr_prev <= 1'b0;
      value_out <= iotr_pkg::RST_OVR;
    end
    else
    begin
      ddr_prev <= input_ddr_clock;
      if (ddr_rise)
        value_out <= value_in;
    end
  end

  a_latch_holds: assert property (@(posedge clk) disable iff (reset)
    !(input_ddr_clock && !ddr_prev) |=> $stable(value_out))
    else $error("override value changed without a data clock edge");

  a_latch_takes: assert property (@(posedge clk) disable iff (reset)
    (input_ddr_clock && !ddr_prev) |=> value_out == $past(value_in))
    else $error("override value not captured on data clock edge");

endmodule : iotr_ovr_latch

/* File: src/iotr_regs.sv */
// I/O test pattern, output override and group delay register group
//
// How it works
// - check words three to seven: 16-bit registers at consecutive indices.
// - check words three, four, five reset to default reference values.
// - check words six and seven reset to their default reference values.
// - strobe routing bit passes output strobe to the core; resets to zero.
// - ramp bit replaces received data with a ramp at FIFO input.
// - override enable puts the override value on every converter output.
// - override value resets to zero; reaches outputs via data clock latch.
// - override value follows the global sample format selection.
// - trims for channels A and B sit in upper and lower bytes.
// - trims for channels C and D sit in the next register likewise.
// - control word resets with one factory bit set; reserved bits kept.
`timescale 1ns/10ps
module iotr_regs
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic output_strobe,
  output logic core_strobe,
  input wire logic [15:0] rx_data,
  input wire logic rx_valid,
  output logic [15:0] fifo_in_data,
  output logic fifo_in_valid,
  input wire logic sample_twos,
  input wire logic input_ddr_clock,
  input wire logic [15:0] core_data_a,
  input wire logic [15:0] core_data_b,
  input wire logic [15:0] core_data_c,
  input wire logic [15:0] core_data_d,
  output logic [15:0] dac_data_a,
  output logic [15:0] dac_data_b,
  output logic [15:0] dac_data_c,
  output logic [15:0] dac_data_d,
  output logic [7:0] delay_trim_a,
  output logic [7:0] delay_trim_b,
  output logic [7:0] delay_trim_c,
  output logic [7:0] delay_trim_d,
  output logic [15:0] check_word_three,
  output logic [15:0] check_word_four,
  output logic [15:0] check_word_five,
  output logic [15:0] check_word_six,
  output logic [15:0] check_word_seven,
  output logic [15:0] factory_ctrl
);

  logic [15:0] regs [0:iotr_pkg::REG_COUNT-1];
  logic [15:0] ramp_count;
  logic [15:0] dac_q [0:3];
  logic [15:0] ovr_latched;

  wire setup_phase;
  wire access_phase;
  wire [5:0] word_idx;
  wire addr_hit;
  wire [3:0] slot;
  wire [15:0] read_word;
  wire [15:0] next_word;
  wire wr_en;
  wire [15:0] ctrl;
  wire strobe_sel;
  wire ramp_ena;
  wire ovr_ena;
  wire [15:0] ovr_fmt;
  wire [15:0] core_in [0:3];

  // APB decode: aligned words between the first and last index
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable & pready;
  assign word_idx = paddr[7:2];
  assign addr_hit = (paddr[1:0] == 2'b00) &&
    (word_idx >= iotr_pkg::IDX_FIRST) && (word_idx <= iotr_pkg::IDX_LAST);
  assign slot = 4'(word_idx - iotr_pkg::IDX_FIRST);
  assign read_word = addr_hit ? regs[slot] : iotr_pkg::ZERO_WORD;
  assign wr_en = access_phase & pwrite & addr_hit;

  // Byte lanes merge write data over the current word
  assign next_word = {pstrb[1] ? pwdata[15:8] : read_word[15:8],
    pstrb[0] ? pwdata[7:0] : read_word[7:0]};

  // Control word fields
  assign ctrl = regs[iotr_pkg::SLOT_CTRL];
  assign strobe_sel = ctrl[iotr_pkg::CTRL_STROBE_BIT];
  assign ramp_ena = ctrl[iotr_pkg::CTRL_RAMP_BIT];
  assign ovr_ena = ctrl[iotr_pkg::CTRL_OVR_BIT];

  // Two's complement override is turned to offset binary when sample_twos is low
  assign ovr_fmt = sample_twos ? ovr_latched :
    {~ovr_latched[iotr_pkg::SAMPLE_MSB],
     ovr_latched[iotr_pkg::SAMPLE_MSB-1:0]};

  // Channel inputs gathered for the per-channel loop
  assign core_in[0] = core_data_a;
  assign core_in[1] = core_data_b;
  assign core_in[2] = core_data_c;
  assign core_in[3] = core_data_d;

  // APB answer: zero wait states, error on unmapped or unaligned address
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= iotr_pkg::ZERO_BUS;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~addr_hit;
      prdata <= (setup_phase & ~pwrite) ? {16'h0000, read_word} :
        iotr_pkg::ZERO_BUS;
    end
  end

  // Register storage, one word per slot, reserved bits kept as written
  generate
    for (genvar i = 0; i < iotr_pkg::REG_COUNT; i++)
    begin : g_reg
      always_ff @(posedge clk)
      begin
        if (reset)
          regs[i] <= iotr_pkg::RST_TABLE[i];
        else if (wr_en && slot == 4'(i))
          regs[i] <= next_word;
      end
    end
  endgenerate

  // Strobe routing and ramp insertion at the FIFO input
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      core_strobe <= 1'b0;
      fifo_in_data <= iotr_pkg::ZERO_WORD;
      fifo_in_valid <= 1'b0;
      ramp_count <= iotr_pkg::ZERO_WORD;
    end
    else
    begin
      core_strobe <= strobe_sel & output_strobe;
      fifo_in_valid <= rx_valid;
      if (!ramp_ena)
        ramp_count <= iotr_pkg::ZERO_WORD;
      else if (rx_valid)
        ramp_count <= ramp_count + iotr_pkg::RAMP_STEP;
      if (rx_valid)
        fifo_in_data <= ramp_ena ? ramp_count : rx_data;
    end
  end

  // Override value reaches the outputs only through the data clock latch
  iotr_ovr_latch u_ovr_latch
  (
    .clk(clk),
    .reset(reset),
    .input_ddr_clock(input_ddr_clock),
    .value_in(regs[iotr_pkg::SLOT_OVR]),
    .value_out(ovr_latched)
  );

  // Per-channel output select
  generate
    for (genvar ch = 0; ch < 4; ch++)
    begin : g_chan
      always_ff @(posedge clk)
      begin
        if (reset)
          dac_q[ch] <= iotr_pkg::ZERO_WORD;
        else
          dac_q[ch] <= ovr_ena ? ovr_fmt : core_in[ch];
      end
    end
  endgenerate

  // Outputs straight from the storage flops
  assign dac_data_a = dac_q[0];
  assign dac_data_b = dac_q[1];
  assign dac_data_c = dac_q[2];
  assign dac_data_d = dac_q[3];
  assign delay_trim_a = regs[iotr_pkg::SLOT_TRIM_AB][15:iotr_pkg::TRIM_HI_LSB];
  assign delay_trim_b = regs[iotr_pkg::SLOT_TRIM_AB][7:0];
  assign delay_trim_c = regs[iotr_pkg::SLOT_TRIM_CD][15:iotr_pkg::TRIM_HI_LSB];
  assign delay_trim_d = regs[iotr_pkg::SLOT_TRIM_CD][7:0];
  assign check_word_three = regs[iotr_pkg::SLOT_TEST3];
  assign check_word_four = regs[iotr_pkg::SLOT_TEST4];
  assign check_word_five = regs[iotr_pkg::SLOT_TEST5];
  assign check_word_six = regs[iotr_pkg::SLOT_TEST6];
  assign check_word_seven = regs[iotr_pkg::SLOT_TEST7];
  assign factory_ctrl = ctrl;

  // Sequences of an APB transfer and of two ramp samples
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_full_write(logic [3:0] s);
    psel && penable && pready && pwrite && addr_hit && slot == s &&
      pstrb[1:0] == 2'b11;
  endsequence

  sequence s_ramp_two;
    rx_valid && ramp_ena ##1 rx_valid && ramp_ena;
  endsequence

  a_apb_answer: assert property (@(posedge clk) disable iff (reset)
    s_setup |=> pready && psel && penable ##1 !pready)
    else $error("APB answer not one cycle after setup");

  a_defaults_low: assert property (@(posedge clk)
    $fell(reset) |-> check_word_three == iotr_pkg::RST_TEST3 &&
      check_word_four == iotr_pkg::RST_TEST4 &&
      check_word_five == iotr_pkg::RST_TEST5)
    else $error("check words three to five wrong after reset");

  a_defaults_high: assert property (@(posedge clk)
    $fell(reset) |-> check_word_six == iotr_pkg::RST_TEST6 &&
      check_word_seven == iotr_pkg::RST_TEST7)
    else $error("check words six and seven wrong after reset");

  a_ctrl_reset: assert property (@(posedge clk)
    $fell(reset) |-> factory_ctrl == iotr_pkg::RST_CTRL && !core_strobe)
    else $error("control word wrong after reset");

  a_word_seven_write: assert property (@(posedge clk) disable iff (reset)
    s_full_write(iotr_pkg::SLOT_TEST7) |=>
      check_word_seven == $past(pwdata[15:0]))
    else $error("check word seven did not take the write");

  a_others_kept: assert property (@(posedge clk) disable iff (reset)
    s_full_write(iotr_pkg::SLOT_OVR) |=>
      $stable(check_word_three) && $stable(factory_ctrl))
    else $error("write to override value disturbed another word");

  a_trim_write: assert property (@(posedge clk) disable iff (reset)
    s_full_write(iotr_pkg::SLOT_TRIM_CD) |=>
      delay_trim_c == $past(pwdata[15:8]) &&
      delay_trim_d == $past(pwdata[7:0]))
    else $error("trim C/D fields not placed as written");

  a_strobe_route: assert property (@(posedge clk) disable iff (reset)
    ##1 core_strobe == $past(strobe_sel && output_strobe))
    else $error("output strobe routing wrong");

  a_pass_through: assert property (@(posedge clk) disable iff (reset)
    rx_valid && !ramp_ena |=> fifo_in_data == $past(rx_data))
    else $error("received data not passed unchanged");

  a_ramp_step: assert property (@(posedge clk) disable iff (reset)
    s_ramp_two |=>
      fifo_in_data == $past(fifo_in_data) + iotr_pkg::RAMP_STEP)
    else $error("ramp did not step by one");

  a_override_out: assert property (@(posedge clk) disable iff (reset)
    ovr_ena && sample_twos |=>
      dac_data_a == $past(ovr_latched) && dac_data_d == $past(ovr_latched))
    else $error("override value not on outputs");

  a_override_fmt: assert property (@(posedge clk) disable iff (reset)
    ovr_ena && !sample_twos |=>
      dac_data_b[15] != $past(ovr_latched[15]) &&
      dac_data_b[14:0] == $past(ovr_latched[14:0]))
    else $error("offset binary override not converted");

endmodule : iotr_regs

/* File: sim/iotr_regs_tb_top.sv */
// Self-checking bench for the I/O test and override register group
`timescale 1ns/10ps
module iotr_regs_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, core_strobe, fifo_in_valid, rerr;
  logic [31:0] prdata, rdat;
  logic output_strobe = 1'b0, rx_valid = 1'b0;
  logic sample_twos = 1'b1, input_ddr_clock = 1'b0;
  logic [15:0] rx_data = 16'h0000;
  logic [15:0] core_data_a = 16'h0000, core_data_b = 16'h0000;
  logic [15:0] core_data_c = 16'h0000, core_data_d = 16'h0000;
  logic [15:0] fifo_in_data, dac_data_a, dac_data_b, dac_data_c, dac_data_d;
  logic [7:0] delay_trim_a, delay_trim_b, delay_trim_c, delay_trim_d;
  logic [15:0] check_word_three, check_word_four, check_word_five;
  logic [15:0] check_word_six, check_word_seven, factory_ctrl;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Device under test
  iotr_regs u_iotr_regs
  (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .output_strobe(output_strobe), .core_strobe(core_strobe),
    .rx_data(rx_data), .rx_valid(rx_valid), .fifo_in_data(fifo_in_data),
    .fifo_in_valid(fifo_in_valid), .sample_twos(sample_twos),
    .input_ddr_clock(input_ddr_clock), .core_data_a(core_data_a),
    .core_data_b(core_data_b), .core_data_c(core_data_c),
    .core_data_d(core_data_d), .dac_data_a(dac_data_a),
    .dac_data_b(dac_data_b), .dac_data_c(dac_data_c),
    .dac_data_d(dac_data_d), .delay_trim_a(delay_trim_a),
    .delay_trim_b(delay_trim_b), .delay_trim_c(delay_trim_c),
    .delay_trim_d(delay_trim_d), .check_word_three(check_word_three),
    .check_word_four(check_word_four), .check_word_five(check_word_five),
    .check_word_six(check_word_six), .check_word_seven(check_word_seven),
    .factory_ctrl(factory_ctrl)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Cut a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr,
    input logic [15:0] wd, input logic [3:0] st);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {16'h0000, wd};
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Ends when pready is seen high, or at the bench timeout
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [15:0] v);
    apb(1'b1, {idx, 2'b00}, v, 4'hf);
  endtask : wr

  task automatic rd(input logic [5:0] idx);
    apb(1'b0, {idx, 2'b00}, 16'h0000, 4'h0);
  endtask : rd

  // Distinct value per slot; control keeps its factory bit
  function automatic logic [15:0] val(input int i);
    return (i == 5) ? 16'h6005 : {i[3:0], 4'hc, ~i[3:0], 4'h3};
  endfunction : val

  // Reset values at the ports and over the bus
  task automatic t_reset();
    logic [15:0] want;
    check("ctrl port", factory_ctrl, 16'h0004);
    check("word five", check_word_five, 16'h1616);
    check("word six", check_word_six, 16'haaaa);
    check("trims", {delay_trim_a, delay_trim_d}, 16'h0000);
    for (int i = 0; i < 9; i++)
    begin
      want = iotr_pkg::RST_TABLE[i];
      rd(iotr_pkg::IDX_FIRST + 6'(i));
      check("reset", rdat[15:0], want);
    end
  endtask : t_reset

  // Write all, read all back, then a single-lane write
  task automatic t_rw();
    for (int i = 0; i < 9; i++)
      wr(iotr_pkg::IDX_FIRST + 6'(i), val(i));
    for (int i = 0; i < 9; i++)
    begin
      rd(iotr_pkg::IDX_FIRST + 6'(i));
      check("readback", rdat[15:0], val(i));
    end
    check("word three", check_word_three, val(0));
    check("word seven", check_word_seven, val(4));
    check("trim ab", {delay_trim_a, delay_trim_b}, val(6));
    check("trim cd", {delay_trim_c, delay_trim_d}, val(7));
    apb(1'b1, {iotr_pkg::IDX_TEST4, 2'b00}, 16'hffff, 4'h1);
    rd(iotr_pkg::IDX_TEST4);
    check("lane", rdat[15:0], 16'h1cff);
    check("word four", check_word_four, 16'h1cff);
  endtask : t_rw

  // Unmapped and unaligned accesses
  task automatic t_bad();
    wr(6'h31, 16'h5555);
    check("bad wr", {15'h0000, rerr}, 16'h0001);
    rd(6'h27);
    check("bad rd", {15'h0000, rerr}, 16'h0001);
    check("bad data", rdat[31:16] | rdat[15:0], 16'h0000);
    apb(1'b0, 8'ha1, 16'h0000, 4'h0);
    check("unaligned", {15'h0000, rerr}, 16'h0001);
    rd(iotr_pkg::IDX_OVR);
    check("ovr kept", rdat[15:0], val(8));
  endtask : t_bad

  // Strobe routing on and off
  task automatic t_strobe();
    wr(iotr_pkg::IDX_CTRL, 16'h4004);
    output_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    check("strobe on", {15'h0000, core_strobe}, 16'h0001);
    wr(iotr_pkg::IDX_CTRL, 16'h0004);
    // Routed strobe is registered one cycle behind the control word
    @(posedge clk);
    check("strobe off", {15'h0000, core_strobe}, 16'h0000);
    output_strobe <= 1'b0;
  endtask : t_strobe

  // Ramp insertion, then plain pass-through
  task automatic t_ramp();
    wr(iotr_pkg::IDX_CTRL, 16'h2004);
    rx_data <= 16'hbeef;
    rx_valid <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      check("ramp", fifo_in_data, 16'(i));
    end
    rx_valid <= 1'b0;
    wr(iotr_pkg::IDX_CTRL, 16'h0004);
    rx_valid <= 1'b1;
    repeat (2) @(posedge clk);
    check("pass", fifo_in_data, 16'hbeef);
    check("pass vld", {15'h0000, fifo_in_valid}, 16'h0001);
    rx_valid <= 1'b0;
  endtask : t_ramp

  // Output override through the data clock latch
  task automatic t_ovr();
    core_data_a <= 16'h1111;
    core_data_b <= 16'h2222;
    core_data_c <= 16'h3333;
    core_data_d <= 16'h4444;
    wr(iotr_pkg::IDX_OVR, 16'h1234);
    wr(iotr_pkg::IDX_CTRL, 16'h0005);
    // Outputs follow the enable one cycle after the write lands
    @(posedge clk);
    check("no clock", dac_data_b, 16'h0000);
    input_ddr_clock <= 1'b1;
    repeat (4) @(posedge clk);
    check("ovr a", dac_data_a, 16'h1234);
    check("ovr d", dac_data_d, 16'h1234);
    sample_twos <= 1'b0;
    repeat (2) @(posedge clk);
    check("offset", dac_data_c, 16'h9234);
    wr(iotr_pkg::IDX_OVR, 16'h0f0f);
    repeat (2) @(posedge clk);
    check("held", dac_data_b, 16'h9234);
    input_ddr_clock <= 1'b0;
    @(posedge clk);
    input_ddr_clock <= 1'b1;
    repeat (4) @(posedge clk);
    check("new ovr", dac_data_a, 16'h8f0f);
    wr(iotr_pkg::IDX_CTRL, 16'h0004);
    @(posedge clk);
    check("ovr off", dac_data_b, 16'h2222);
  endtask : t_ovr

  // Counts, verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rw();
    t_bad();
    wr(iotr_pkg::IDX_CTRL, 16'h0004);
    t_strobe();
    t_ramp();
    t_ovr();
    wrap_up();
  end
endmodule : iotr_regs_tb_top
